// ===== rtl/ude_ctl.sv
// controller end: apb slave that runs register accesses on the device port
`timescale 1ns/1ps
`default_nettype none
module ude_ctl (
	input  wire logic        mclk,    // 40 MHz clock
	input  wire logic        rst_b,   // async reset, low
	ude_if.ctl               link,    // register port to device
	input  wire logic        psel,    // apb select
	input  wire logic        penable, // apb enable
	input  wire logic        pwrite,  // apb direction
	input  wire logic [7:0]  paddr,   // apb byte address
	input  wire logic [31:0] pwdata,  // apb write data
	output logic      [31:0] prdata,  // apb read data
	output logic             pready,  // apb ready
	output logic             pslverr, // apb error, always low
	output logic             irq      // level interrupt
);
	typedef enum logic [2:0] {IDLE = 3'b001, ISSUE = 3'b010, CAPT = 3'b100} udeSt_t;
	udeSt_t      st_q, st_d;
	logic        sel_q, sel_d, wr_q, wr_d, irq_d, ready_d, prevPin_q;
	logic [3:0]  addr_q, addr_d;
	logic [7:0]  wdat_q, wdat_d, rdat_q, rdat_d;
	logic [1:0]  ist_q, ist_d, mask_q, mask_d;
	logic [31:0] prdata_d;
	logic        acc, setup;
	assign setup = psel && !penable;
	assign acc   = psel && penable && pready;

	always_comb begin
		st_d     = st_q;
		sel_d    = 1'b0;
		wr_d     = wr_q;
		addr_d   = addr_q;
		wdat_d   = wdat_q;
		rdat_d   = rdat_q;
		mask_d   = mask_q;
		ist_d    = ist_q;
		prdata_d = 32'h0000_0000;
		ready_d  = setup;
		if (acc && pwrite && paddr == ude_pkg::APB_MASK)
			mask_d = pwdata[1:0];
		// only the bits handed out in prdata clear, so an event landing in the setup cycle is not lost
		if (acc && !pwrite && paddr == ude_pkg::APB_IRQ)
			ist_d = ist_q & ~prdata[1:0];
		case (st_q)
			IDLE: begin
				// a command written while busy is ignored
				if (acc && pwrite && paddr == ude_pkg::APB_CMD) begin
					addr_d = pwdata[3:0];
					wdat_d = pwdata[15:8];
					wr_d   = pwdata[ude_pkg::CMD_WRITE];
					sel_d  = 1'b1;
					st_d   = ISSUE;
				end
			end
			ISSUE: st_d = CAPT;
			CAPT: begin
				rdat_d = link.regRdata;
				ist_d[ude_pkg::IRQ_DONE] = 1'b1;
				st_d = IDLE;
			end
			default: st_d = IDLE;
		endcase
		if (link.interruptRequestPin && !prevPin_q)
			ist_d[ude_pkg::IRQ_DEVPIN] = 1'b1;
		if (setup && !pwrite) begin
			case (paddr)
				ude_pkg::APB_CMD:  prdata_d = {15'h0000, wr_q, wdat_q, 4'h0, addr_q};
				ude_pkg::APB_STAT: prdata_d = {15'h0000, link.interruptRequestPin, rdat_q, 7'h00, st_q != IDLE};
				ude_pkg::APB_IRQ:  prdata_d = {30'h0000_0000, ist_q};
				ude_pkg::APB_MASK: prdata_d = {30'h0000_0000, mask_q};
				default:           prdata_d = 32'h0000_0000;
			endcase
		end
		irq_d = |(ist_d & mask_d);
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_q       <= IDLE;
			sel_q      <= 1'b0;
			wr_q       <= 1'b0;
			addr_q     <= 4'h0;
			wdat_q     <= 8'h00;
			rdat_q     <= 8'h00;
			ist_q      <= 2'h0;
			mask_q     <= 2'h0;
			prevPin_q  <= 1'b0;
			prdata     <= 32'h0000_0000;
			pready     <= 1'b0;
			irq        <= 1'b0;
		end else begin
			st_q       <= st_d;
			sel_q      <= sel_d;
			wr_q       <= wr_d;
			addr_q     <= addr_d;
			wdat_q     <= wdat_d;
			rdat_q     <= rdat_d;
			ist_q      <= ist_d;
			mask_q     <= mask_d;
			prevPin_q  <= link.interruptRequestPin;
			prdata     <= prdata_d;
			pready     <= ready_d;
			irq        <= irq_d;
		end
	end

	assign pslverr       = 1'b0;
	assign link.regSel   = sel_q;
	assign link.regWr    = wr_q;
	assign link.regAddr  = addr_q;
	assign link.regWdata = wdat_q;
endmodule
`default_nettype wire

// ===== rtl/ude_device.sv
// usb device event and interrupt logic with its local register port
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ude_device #(
	parameter int SUSP_CYC = ude_pkg::SUSP_CYC,
	parameter int STOP_CYC = ude_pkg::STOP_CYC
) (
	input  wire logic                        mclk,     // 40 MHz clock
	input  wire logic                        rst_b,    // async reset, low
	ude_if.dev                               link,     // register port to controller
	input  wire logic                        dpPin,    // D+ line
	input  wire logic                        dmPin,    // D- line
	input  wire logic                        sofDet,   // start-of-frame seen, pulse
	input  wire logic [ude_pkg::NUM_EP-1:0]  inToken,  // IN token per endpoint, pulse
	input  wire logic [ude_pkg::NUM_EP-1:0]  hostAck,  // host ACK per endpoint, pulse
	output logic      [ude_pkg::NUM_EP-1:0]  txStart,  // send armed packet, pulse
	output logic                             txShort,  // started packet is short
	output logic      [ude_pkg::CNT_W-1:0]   txLen,    // byte count of started packet
	output logic                             oscStop   // oscillator stop request
);
	localparam int N = ude_pkg::NUM_EP;
	localparam int W = ude_pkg::CNT_W;
	localparam int IDLE_W = ude_pkg::IDLE_W;
	localparam logic [7:0] SE0_LIM = 8'(ude_pkg::SE0_CYC);

	// ******************************
	// line sampling
	// ******************************
	logic dpS1_q, dpS2_q, dmS1_q, dmS2_q;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			dpS1_q <= 1'b0;
			dpS2_q <= 1'b0;
			dmS1_q <= 1'b0;
			dmS2_q <= 1'b0;
		end else begin
			dpS1_q <= dpPin;
			dpS2_q <= dpS1_q;
			dmS1_q <= dmPin;
			dmS2_q <= dmS1_q;
		end
	end
	logic lineSe0, lineJ;
	assign lineSe0 = !dpS2_q && !dmS2_q;
	assign lineJ   = dpS2_q && !dmS2_q;

	// ******************************
	// registers and bus decode
	// ******************************
	logic [N-1:0] txDir_q, txDir_d, inten1_q, inten1_d;
	logic [1:0]   bulk_q, bulk_d;
	logic [3:0]   st2_q, st2_d, inten2_q, inten2_d, evt;
	logic [7:0]   rdata_q, rdata_d;
	logic         irq_q, irq_d;
	logic         wrEn;
	logic [N-1:0] txRdy_q, txRdy_d, sent_q, sent_d, elig, armWr, qWr, txStart_d;
	logic [W-1:0] qCnt_q [N];
	logic [W-1:0] qCnt_d [N];
	logic         txShort_d;
	logic [W-1:0] txLen_d;
	assign wrEn = link.regSel && link.regWr;

	// ******************************
	// transmit endpoints
	// ******************************
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gEp
			if (g < 3) begin : gGen
				assign elig[g] = txDir_q[g];
			end else begin : gIso
				assign elig[g] = txDir_q[g] && bulk_q[g-3];
			end
			assign armWr[g] = wrEn && link.regAddr == ude_pkg::REG_EPSTAT0 + 4'(g)
				&& link.regWdata[ude_pkg::EPSTAT_TXRDY];
			assign qWr[g] = wrEn && link.regAddr == ude_pkg::REG_TXQ0 + 4'(g);
			always_comb begin
				txRdy_d[g]   = txRdy_q[g];
				sent_d[g]    = sent_q[g];
				qCnt_d[g]    = qCnt_q[g];
				txStart_d[g] = 1'b0;
				// one packet is loaded, then armed; bytes past a full packet are dropped
				if (qWr[g] && qCnt_q[g] < W'(ude_pkg::MAX_PKT))
					qCnt_d[g] = qCnt_q[g] + W'(1);
				if (inToken[g] && txRdy_q[g] && elig[g] && !sent_q[g]) begin
					txStart_d[g] = 1'b1;
					sent_d[g]    = 1'b1;
				end
				// queue frees only after the host acked what was sent
				if (hostAck[g] && sent_q[g]) begin
					txRdy_d[g] = 1'b0;
					sent_d[g]  = 1'b0;
					qCnt_d[g]  = '0;
				end
				if (armWr[g])
					txRdy_d[g] = 1'b1;
			end
			always_ff @(posedge mclk or negedge rst_b) begin
				if (!rst_b) begin
					txRdy_q[g] <= 1'b0;
					sent_q[g]  <= 1'b0;
					qCnt_q[g]  <= '0;
				end else begin
					txRdy_q[g] <= txRdy_d[g];
					sent_q[g]  <= sent_d[g];
					qCnt_q[g]  <= qCnt_d[g];
				end
			end
		end
	endgenerate

	always_comb begin
		txShort_d = 1'b0;
		txLen_d   = '0;
		for (int i = 0; i < N; i++) begin
			if (txStart_d[i]) begin
				txLen_d   = qCnt_q[i];
				txShort_d = qCnt_q[i] < W'(ude_pkg::MAX_PKT);
			end
		end
	end

	// ******************************
	// bus reset and suspend detection
	// ******************************
	logic [7:0]        se0Cnt_q, se0Cnt_d;
	logic              longSe0_q, longSe0_d;
	logic [IDLE_W-1:0] idleCnt_q, idleCnt_d;
	logic              osc_q, osc_d;
	always_comb begin
		se0Cnt_d  = lineSe0 ? se0Cnt_q : 8'h00;
		longSe0_d = longSe0_q;
		idleCnt_d = lineJ ? idleCnt_q : '0;
		osc_d     = osc_q && lineJ;
		evt       = 4'h0;
		evt[ude_pkg::ST2_SOF] = sofDet;
		if (lineSe0 && se0Cnt_q < SE0_LIM)
			se0Cnt_d = se0Cnt_q + 8'h01;
		if (lineSe0 && se0Cnt_q == SE0_LIM - 8'h01) begin
			evt[ude_pkg::ST2_RSTA] = 1'b1;
			longSe0_d = 1'b1;
		end
		if (!lineSe0) begin
			longSe0_d = 1'b0;
			evt[ude_pkg::ST2_RSTR] = longSe0_q && lineJ;
		end
		if (lineJ && idleCnt_q < IDLE_W'(SUSP_CYC + STOP_CYC))
			idleCnt_d = idleCnt_q + IDLE_W'(1);
		if (lineJ && idleCnt_q == IDLE_W'(SUSP_CYC - 1))
			evt[ude_pkg::ST2_SUSP] = 1'b1;
		// oscillator stays stopped until the line leaves idle
		if (lineJ && idleCnt_q == IDLE_W'(SUSP_CYC + STOP_CYC - 1))
			osc_d = 1'b1;
	end

	// ******************************
	// register file
	// ******************************
	always_comb begin
		txDir_d  = txDir_q;
		bulk_d   = bulk_q;
		inten1_d = inten1_q;
		inten2_d = inten2_q;
		st2_d    = st2_q;
		rdata_d  = 8'h00;
		if (wrEn) begin
			case (link.regAddr)
				ude_pkg::REG_CONFIG: begin
					txDir_d = link.regWdata[N-1:0];
					bulk_d  = {link.regWdata[ude_pkg::CFG_BULK5], link.regWdata[ude_pkg::CFG_BULK4]};
				end
				ude_pkg::REG_INTEN1: inten1_d = link.regWdata[N-1:0];
				ude_pkg::REG_INTEN2: inten2_d = link.regWdata[3:0];
				ude_pkg::REG_INTST2: st2_d = st2_q & ~link.regWdata[3:0];
				default: ;
			endcase
		end
		// a new event in the clearing cycle is kept
		st2_d = st2_d | evt;
		if (link.regSel && !link.regWr) begin
			case (link.regAddr)
				ude_pkg::REG_CONFIG: rdata_d = {1'b0, bulk_q, txDir_q};
				ude_pkg::REG_INTEN1: rdata_d = {3'h0, inten1_q};
				ude_pkg::REG_INTEN2: rdata_d = {4'h0, inten2_q};
				ude_pkg::REG_INTST2: rdata_d = {4'h0, st2_q};
				default: begin
					for (int i = 0; i < N; i++) begin
						if (link.regAddr == ude_pkg::REG_EPSTAT0 + 4'(i))
							rdata_d = {6'h00, txRdy_q[i], 1'b0};
						if (link.regAddr == ude_pkg::REG_TXQ0 + 4'(i))
							rdata_d = {1'b0, qCnt_q[i]};
					end
				end
			endcase
		end
		// next values are used so arming drops the pin on the same edge
		irq_d = |(elig & ~txRdy_d & inten1_q) || |(st2_d & inten2_q);
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			txDir_q   <= '0;
			bulk_q    <= 2'h0;
			inten1_q  <= '0;
			inten2_q  <= 4'h0;
			st2_q     <= 4'h0;
			rdata_q   <= 8'h00;
			irq_q     <= 1'b0;
			se0Cnt_q  <= 8'h00;
			longSe0_q <= 1'b0;
			idleCnt_q <= '0;
			osc_q     <= 1'b0;
			txStart   <= '0;
			txShort   <= 1'b0;
			txLen     <= '0;
		end else begin
			txDir_q   <= txDir_d;
			bulk_q    <= bulk_d;
			inten1_q  <= inten1_d;
			inten2_q  <= inten2_d;
			st2_q     <= st2_d;
			rdata_q   <= rdata_d;
			irq_q     <= irq_d;
			se0Cnt_q  <= se0Cnt_d;
			longSe0_q <= longSe0_d;
			idleCnt_q <= idleCnt_d;
			osc_q     <= osc_d;
			txStart   <= txStart_d;
			txShort   <= txShort_d;
			txLen     <= txLen_d;
		end
	end

	assign link.regRdata           = rdata_q;
	assign link.interruptRequestPin = irq_q;
	assign oscStop                 = osc_q;
endmodule
`default_nettype wire

// ===== rtl/ude_if.sv
// local register port between the device and its controller
`timescale 1ns/1ps
`default_nettype none
interface ude_if;
	logic       regSel;
	logic       regWr;
	logic [3:0] regAddr;
	logic [7:0] regWdata;
	logic [7:0] regRdata;
	logic       interruptRequestPin;
	modport dev (input regSel, regWr, regAddr, regWdata, output regRdata, interruptRequestPin);
	modport ctl (output regSel, regWr, regAddr, regWdata, input regRdata, interruptRequestPin);
endinterface
`default_nettype wire

// ===== rtl/ude_pkg.sv
// shared constants for the usb device event block and its controller
package ude_pkg;
	localparam int NUM_EP       = 5;
	localparam int MAX_PKT      = 64;
	localparam int CNT_W        = 7;
	localparam int IDLE_W       = 18;
	localparam int MCLK_MHZ     = 40;
	// line timing, figures in their own units
	localparam int SE0_NS       = 2500;
	localparam int SUSP_US      = 3000;
	localparam int STOP_US      = 2000;
	localparam int SE0_CYC      = (SE0_NS * MCLK_MHZ + 999) / 1000;
	localparam int SUSP_CYC     = SUSP_US * MCLK_MHZ;
	localparam int STOP_CYC     = STOP_US * MCLK_MHZ;
	// device register indices (endpoint_status_reg 0..4, endpoint_transmit_queue 9..13)
	localparam logic [3:0] REG_EPSTAT0 = 4'h0;
	localparam logic [3:0] REG_CONFIG  = 4'h5;
	localparam logic [3:0] REG_INTEN1  = 4'h6;
	localparam logic [3:0] REG_INTST2  = 4'h7;
	localparam logic [3:0] REG_INTEN2  = 4'h8;
	localparam logic [3:0] REG_TXQ0    = 4'h9;
	// field positions
	localparam int EPSTAT_TXRDY = 1;
	localparam int CFG_BULK4    = 5;
	localparam int CFG_BULK5    = 6;
	localparam int ST2_SOF      = 0;
	localparam int ST2_RSTA     = 1;
	localparam int ST2_RSTR     = 2;
	localparam int ST2_SUSP     = 3;
	// controller apb offsets
	localparam logic [7:0] APB_CMD  = 8'h00;
	localparam logic [7:0] APB_STAT = 8'h04;
	localparam logic [7:0] APB_IRQ  = 8'h08;
	localparam logic [7:0] APB_MASK = 8'h0C;
	localparam int CMD_WRITE    = 16;
	localparam int IRQ_DONE     = 0;
	localparam int IRQ_DEVPIN   = 1;
endpackage

// ===== verif/tb_usb_device_event_interrupts.sv
// self-checking bench for the usb device event block and its controller
`timescale 1ns/1ps
`default_nettype none
module tb_usb_device_event_interrupts;
	logic        mclk, rst_b, psel, penable, pwrite, dpPin, dmPin, sofDet;
	logic        pready, pslverr, irq, txShort, oscStop;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [4:0]  inToken, hostAck, txStart;
	logic [6:0]  txLen;
	int          err_count, cmp_count, cyc, lens [4];
	ude_if u ();
	ude_device #(.SUSP_CYC(40), .STOP_CYC(20)) i_ude_device (.mclk(mclk), .rst_b(rst_b), .link(u), .dpPin(dpPin),
		.dmPin(dmPin), .sofDet(sofDet), .inToken(inToken), .hostAck(hostAck), .txStart(txStart), .txShort(txShort),
		.txLen(txLen), .oscStop(oscStop));
	ude_ctl i_ude_ctl (.mclk(mclk), .rst_b(rst_b), .link(u), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
	ude_asserts i_ude_asserts (.mclk(mclk), .rst_b(rst_b), .regSel(u.regSel), .regWr(u.regWr), .regAddr(u.regAddr),
		.regWdata(u.regWdata), .regRdata(u.regRdata), .interruptRequestPin(u.interruptRequestPin));
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// ****
	// helpers
	// ****
	task automatic final_report();
		if (err_count == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_count++;
			final_report();
		end
	end
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [31:0] expLen(input int n);
		return (n > ude_pkg::MAX_PKT) ? ude_pkg::MAX_PKT : n;
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rv = prdata;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic dev(input logic w, input logic [3:0] i, input logic [7:0] d);
		apb(1'b1, ude_pkg::APB_CMD, {15'h0000, w, d, 4'h0, i});
		do apb(1'b0, ude_pkg::APB_STAT, 32'h0); while (rv[0] !== 1'b0);
	endtask
	task automatic pin(input logic e);
		@(negedge mclk);
		cmp("pin", 32'(e), 32'(u.interruptRequestPin));
	endtask
	task automatic tok(input logic [4:0] t, input logic [4:0] a);
		@(posedge mclk);
		inToken <= t; hostAck <= a;
		@(posedge mclk);
		inToken <= 5'h00; hostAck <= 5'h00;
	endtask
	task automatic line(input logic [1:0] s, input int c);
		@(posedge mclk);
		{dpPin, dmPin} <= s;
		repeat (c) @(posedge mclk);
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		{psel, penable, pwrite, sofDet} = 4'h0;
		paddr = 8'h00; pwdata = 32'h0; inToken = 5'h00; hostAck = 5'h00;
		dpPin = 1'b0; dmPin = 1'b1; rst_b = 1'b0;
		void'($urandom(23));
		lens = '{64, 63, 66, 1 + int'($urandom % 64)};
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		apb(1'b0, 8'h40, 32'h0); cmp("unmapped", 32'h0, rv);
		cmp("slverr", 32'h0, 32'(pslverr));
		apb(1'b1, ude_pkg::APB_MASK, 32'h2);
		apb(1'b0, ude_pkg::APB_MASK, 32'h0); cmp("mask", 32'h2, rv);
		dev(1'b1, ude_pkg::REG_CONFIG, 8'h3F);
		cmp("masked irq", 32'h0, 32'(irq));
		dev(1'b1, ude_pkg::REG_INTEN1, 8'h1F);
		pin(1'b1);
		cmp("irq", 32'h1, 32'(irq));
		apb(1'b0, ude_pkg::APB_IRQ, 32'h0); cmp("irq reg", 32'h3, rv);
		repeat (2) @(negedge mclk);
		cmp("irq cleared", 32'h0, 32'(irq));
		for (int e = 0; e < 4; e++) begin
			repeat (lens[e]) dev(1'b1, ude_pkg::REG_TXQ0 + 4'(e), 8'($urandom));
			dev(1'b0, ude_pkg::REG_TXQ0 + 4'(e), 8'h00); cmp("count", expLen(lens[e]), 32'(rv[15:8]));
			dev(1'b1, ude_pkg::REG_EPSTAT0 + 4'(e), 8'h02);
		end
		pin(1'b0);
		for (int e = 0; e < 4; e++) begin
			dev(1'b1, ude_pkg::REG_INTEN1, 8'h01 << e);
			tok(5'h01 << e, 5'h00);
			@(negedge mclk);
			cmp("start", 32'h1 << e, 32'(txStart));
			cmp("len", expLen(lens[e]), 32'(txLen));
			cmp("short", 32'(expLen(lens[e]) < ude_pkg::MAX_PKT), 32'(txShort));
			tok(5'h01 << e, 5'h00);
			@(negedge mclk);
			cmp("restart", 32'h0, 32'(txStart));
			pin(1'b0);
			tok(5'h00, 5'h01 << e);
			pin(1'b1);
			dev(1'b0, ude_pkg::REG_EPSTAT0 + 4'(e), 8'h00); cmp("ready bit", 32'h0, 32'(rv[9]));
			dev(1'b1, ude_pkg::REG_EPSTAT0 + 4'(e), 8'h02);
			pin(1'b0);
		end
		dev(1'b1, ude_pkg::REG_INTEN1, 8'h1F);
		dev(1'b1, ude_pkg::REG_CONFIG, 8'h7F);
		pin(1'b1);
		dev(1'b1, ude_pkg::REG_INTEN1, 8'h0F);
		pin(1'b0);
		dev(1'b0, ude_pkg::REG_CONFIG, 8'h00); cmp("config", 32'h7F, 32'(rv[15:8]));
		dev(1'b0, ude_pkg::REG_INTEN1, 8'h00); cmp("enable one", 32'h0F, 32'(rv[15:8]));
		dev(1'b1, ude_pkg::REG_INTEN2, 8'h0F);
		dev(1'b0, ude_pkg::REG_INTEN2, 8'h00); cmp("enable two", 32'h0F, 32'(rv[15:8]));
		@(posedge mclk);
		sofDet <= 1'b1;
		@(posedge mclk);
		sofDet <= 1'b0;
		pin(1'b1);
		dev(1'b1, ude_pkg::REG_INTST2, 8'h00);
		pin(1'b1);
		dev(1'b1, ude_pkg::REG_INTST2, 8'h01);
		pin(1'b0);
		// se0 long then J, se0 short then J, se0 long then K
		line(2'b00, 110); line(2'b10, 5); line(2'b01, 1);
		dev(1'b0, ude_pkg::REG_INTST2, 8'h00); cmp("reset flags", 32'h6, 32'(rv[11:8]));
		dev(1'b1, ude_pkg::REG_INTST2, 8'h0F);
		line(2'b00, 50); line(2'b10, 5); line(2'b01, 1);
		dev(1'b0, ude_pkg::REG_INTST2, 8'h00); cmp("short se0", 32'h0, 32'(rv[11:8]));
		line(2'b00, 110); line(2'b01, 5);
		dev(1'b0, ude_pkg::REG_INTST2, 8'h00); cmp("se0 to K", 32'h2, 32'(rv[11:8]));
		dev(1'b1, ude_pkg::REG_INTST2, 8'h0F);
		line(2'b10, 30);
		pin(1'b0);
		line(2'b10, 20);
		pin(1'b1);
		cmp("osc early", 32'h0, 32'(oscStop));
		line(2'b10, 15);
		cmp("osc stop", 32'h1, 32'(oscStop));
		line(2'b01, 3);
		@(negedge mclk);
		cmp("osc run", 32'h0, 32'(oscStop));
		dev(1'b1, ude_pkg::REG_INTST2, 8'h08);
		pin(1'b0);
		final_report();
	end
endmodule
`default_nettype wire

// ===== verif/ude_asserts.sv
// checker for the register port between controller and device
`timescale 1ns/1ps
`default_nettype none
module ude_asserts (
	input wire logic       mclk,                // clock
	input wire logic       rst_b,               // reset, low
	input wire logic       regSel,              // access strobe
	input wire logic       regWr,               // write when high
	input wire logic [3:0] regAddr,             // register index
	input wire logic [7:0] regWdata,            // write data
	input wire logic [7:0] regRdata,            // read data
	input wire logic       interruptRequestPin  // device interrupt
);
	// ****
	// shadows of what was written
	// ****
	logic [7:0] cfg_q, cfg_d, en1_q, en1_d, en2_q, en2_d;
	logic       rd, wr;
	logic [4:0] elig;
	assign rd = regSel && !regWr;
	assign wr = regSel && regWr;
	// shadows only see writes, so armed state stays unknown here
	assign elig = cfg_q[4:0] & {cfg_q[6:5], 3'h7};
	always_comb begin
		cfg_d = (wr && regAddr == ude_pkg::REG_CONFIG) ? regWdata : cfg_q;
		en1_d = (wr && regAddr == ude_pkg::REG_INTEN1) ? regWdata : en1_q;
		en2_d = (wr && regAddr == ude_pkg::REG_INTEN2) ? regWdata : en2_q;
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_q <= 8'h00;
			en1_q <= 8'h00;
			en2_q <= 8'h00;
		end else begin
			cfg_q <= cfg_d;
			en1_q <= en1_d;
			en2_q <= en2_d;
		end
	end
	// ****
	// properties
	// ****
	pin_quiet_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(elig & en1_q[4:0]) == 5'h00 && en2_q[3:0] == 4'h0 |=> !interruptRequestPin) else $error("pin high unenabled");
	en1_back_a: assert property (@(posedge mclk) disable iff (!rst_b)
		rd && regAddr == ude_pkg::REG_INTEN1 |=> regRdata[4:0] == en1_q[4:0]) else $error("enable one readback");
	cfg_back_a: assert property (@(posedge mclk) disable iff (!rst_b)
		rd && regAddr == ude_pkg::REG_CONFIG |=> regRdata[6:0] == cfg_q[6:0]) else $error("config readback");
	en2_back_a: assert property (@(posedge mclk) disable iff (!rst_b)
		rd && regAddr == ude_pkg::REG_INTEN2 |=> regRdata[3:0] == en2_q[3:0]) else $error("enable two readback");
	queue_sat_a: assert property (@(posedge mclk) disable iff (!rst_b)
		rd && regAddr >= ude_pkg::REG_TXQ0 && regAddr <= 4'hD |=> regRdata <= 8'h40) else $error("count above packet");
	stat_bit0_a: assert property (@(posedge mclk) disable iff (!rst_b)
		rd && regAddr <= 4'h4 |=> !regRdata[0]) else $error("status bit0 set");
	arm_pin_a: assert property (@(posedge mclk) disable iff (!rst_b)
		wr && regAddr <= 4'h4 && regWdata[1] && en2_q[3:0] == 4'h0
		&& (elig & en1_q[4:0] & ~(5'h01 << regAddr)) == 5'h00 |=> !interruptRequestPin) else $error("arm kept pin");
	flag_pin_a: assert property (@(posedge mclk) disable iff (!rst_b)
		rd && regAddr == ude_pkg::REG_INTST2 && !interruptRequestPin
		|=> (regRdata[3:0] & en2_q[3:0]) == 4'h0) else $error("enabled flag without pin");
endmodule
`default_nettype wire
